/* File: hdl/fdod_map.vh */
`ifndef FDOD_MAP_VH
`define FDOD_MAP_VH
// ****************************************************************
// object indexes
// ****************************************************************
`define FDOD_IDX_GUARD_ID 16'h100E
`define FDOD_IDX_SAVE 16'h1010
`define FDOD_IDX_DEFAULTS 16'h1011
`define FDOD_IDX_EMCY_ID 16'h1014
`define FDOD_IDX_HB_CONSUME 16'h1016
`define FDOD_IDX_HB_PRODUCE 16'h1017
`define FDOD_IDX_IDENTITY 16'h1018
`define FDOD_IDX_RUN_CMD 16'h2000
`define FDOD_IDX_SPEED 16'h2010
`define FDOD_IDX_TORQUE 16'h2020
`define FDOD_IDX_TORQUE_OFS 16'h2030
`define FDOD_IDX_IND_READ 16'h2040
`define FDOD_IDX_IND_WRITE 16'h2050
`define FDOD_IDX_IND_READ_RSP 16'h2140
`define FDOD_IDX_IND_WRITE_RSP 16'h2150
`define FDOD_SUB_ENTRIES 8'h00
`define FDOD_SUB_DATA 8'h01
`define FDOD_NUM_ENTRIES 32'h00000001
// ****************************************************************
// magic words, byte 1 in the low byte
// ****************************************************************
`define FDOD_MAGIC_SAVE 32'h65766173
`define FDOD_MAGIC_LOAD 32'h64616F6C
// ****************************************************************
// factory defaults of the option settings
// ****************************************************************
`define FDOD_DEF_GUARD_ID 32'h00000700
`define FDOD_DEF_HB_CONSUME 32'h00000000
`define FDOD_DEF_HB_PRODUCE 32'h00000000
`define FDOD_EMCY_BASE 32'h00000080
// ****************************************************************
// settings memory slots
// ****************************************************************
`define FDOD_SLOT_GUARD 2'h0
`define FDOD_SLOT_CONSUME 2'h1
`define FDOD_SLOT_PRODUCE 2'h2
`define FDOD_SLOT_LAST 2'h3
// ****************************************************************
// command word fields and drive parameter values
// ****************************************************************
`define FDOD_BIT_FWD 0
`define FDOD_BIT_REV 1
`define FDOD_MFI_LO 2
`define FDOD_MFI_HI 7
`define FDOD_BIT_EXT_FAULT 8
`define FDOD_BIT_FAULT_RST 9
`define FDOD_RUN_SRC_NET 8'h03
`define FDOD_TQ_ENABLE_ON 8'h01
`define FDOD_LOOP_SPEED 8'h00
`define FDOD_LOOP_TORQUE 8'h01
// ****************************************************************
// timing
// ****************************************************************
`define FDOD_CLK_KHZ 50000
`define FDOD_HB_UNIT_MS 1
`endif

/* File: hdl/fdod_settings_nvm.v */
`timescale 1ns/1ps
`include "fdod_map.vh"
// ****************************************************************
// non-volatile store for the option settings
// ****************************************************************
module fdod_settings_nvm (
	input wire i_clk, // system clock
	input wire i_we, // write strobe
	input wire [1:0] i_addr, // slot address
	input wire [31:0] i_wdata, // write data
	output reg [31:0] o_rdata // registered read data
);
	reg [31:0] mem [0:3];
	// contents survive reset; power-up image holds the factory defaults
	initial begin
		mem[0] = `FDOD_DEF_GUARD_ID;
		mem[1] = `FDOD_DEF_HB_CONSUME;
		mem[2] = `FDOD_DEF_HB_PRODUCE;
		mem[3] = 32'h00000000;
	end
	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end
endmodule

/* File: hdl/fdod_object_dictionary.v */
`timescale 1ns/1ps
`include "fdod_map.vh"
module fdod_object_dictionary #(
	parameter MS_CYCLES = `FDOD_HB_UNIT_MS * `FDOD_CLK_KHZ
) (
	input wire i_clk, // system clock
	input wire i_sys_rst, // synchronous reset, active high
	input wire i_od_req, // object access strobe
	input wire i_od_we, // 1 write, 0 read
	input wire [15:0] i_od_index, // object index
	input wire [7:0] i_od_subindex, // object subindex
	input wire [31:0] i_od_wdata, // write data
	output reg [31:0] o_od_rdata, // read data
	output reg o_od_ack, // access answered
	output reg o_od_err, // access refused
	input wire i_node_reset, // network node reset command
	input wire i_comm_reset, // network communication reset command
	input wire [6:0] i_node_id, // node address
	input wire i_hb_rx, // heartbeat received from the master
	output reg o_hb_tx, // heartbeat send request pulse
	output reg o_hb_timeout, // consumer heartbeat lost
	input wire [7:0] i_run_source_select, // drive run source parameter
	input wire [7:0] i_control_loop_selector, // drive control loop parameter
	input wire [7:0] i_torque_command_enable, // drive torque enable parameter
	output reg o_run_fwd, // forward run request
	output reg o_run_rev, // reverse run request
	output reg [5:0] o_multi_input_terminals, // first to last multi-function input
	output reg o_network_external_fault, // external fault input
	output reg o_fault_reset, // fault reset request
	output reg [15:0] o_speed_reference, // speed reference
	output reg [15:0] o_speed_limit, // speed limit
	output reg [15:0] o_torque_reference, // torque reference, 0.1 percent
	output reg [15:0] o_torque_limit, // torque limit, 0.1 percent
	output reg o_torque_limit_valid, // torque limit in force
	output reg [15:0] o_torque_offset, // signed torque offset, 0.1 percent
	output reg o_drv_req, // drive register access pulse
	output reg o_drv_we, // drive register write
	output reg [15:0] o_drv_addr, // drive register address
	output reg [15:0] o_drv_wdata, // drive register write data
	input wire i_drv_ack, // drive register access done
	input wire [15:0] i_drv_rdata, // drive register read data or write outcome
	output reg o_busy // settings copy in progress
);
	// arbitrary identity value
	parameter IDENTITY_VALUE = 32'h00000001;
	localparam ST_IDLE = 3'h1;
	localparam ST_RD = 3'h2;
	localparam ST_WR = 3'h4;
	localparam SQ_IDLE = 3'h1;
	localparam SQ_SAVE = 3'h2;
	localparam SQ_LOAD = 3'h4;
	// ****************************************************************
	// helpers
	// ****************************************************************
	function hit;
		input [15:0] idx;
		input [15:0] want;
		hit = (idx == want);
	endfunction
	function [31:0] pack_rsp;
		input [15:0] addr;
		input [15:0] data;
		pack_rsp = {data, addr};
	endfunction
	// ****************************************************************
	// state
	// ****************************************************************
	reg [31:0] guard_message_identifier;
	reg [31:0] heartbeat_consume_timeout;
	reg [31:0] heartbeat_produce_period;
	reg [15:0] run_fault_command_word;
	reg [15:0] speed_reference_word;
	reg [15:0] torque_reference_word;
	reg [15:0] torque_offset_word;
	reg [31:0] indirect_read_request;
	reg [31:0] indirect_write_request;
	reg [31:0] read_response;
	reg [31:0] write_response;
	reg [2:0] acc_state;
	reg [2:0] seq_state;
	reg [1:0] seq_cnt;
	reg seq_rd_valid;
	reg [1:0] seq_rd_slot;
	reg [15:0] ms_cnt;
	reg ms_tick;
	reg [31:0] prod_cnt;
	reg [31:0] cons_cnt;
	reg [31:0] next_rdata;
	reg next_err;
	reg [31:0] nvm_wdata;
	wire [31:0] nvm_rdata;
	wire wr = i_od_req & i_od_we;
	wire nvm_we = (seq_state == SQ_SAVE);
	wire [1:0] nvm_addr = seq_cnt;
	fdod_settings_nvm u_nvm (
		.i_clk(i_clk),
		.i_we(nvm_we),
		.i_addr(nvm_addr),
		.i_wdata(nvm_wdata),
		.o_rdata(nvm_rdata)
	);
	always @* begin
		case (seq_cnt)
			`FDOD_SLOT_GUARD: nvm_wdata = guard_message_identifier;
			`FDOD_SLOT_CONSUME: nvm_wdata = heartbeat_consume_timeout;
			`FDOD_SLOT_PRODUCE: nvm_wdata = heartbeat_produce_period;
			default: nvm_wdata = 32'h00000000;
		endcase
	end
	// ****************************************************************
	// object read mux and refusal
	// ****************************************************************
	always @* begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		case (i_od_index)
			`FDOD_IDX_GUARD_ID: next_rdata = guard_message_identifier;
			`FDOD_IDX_SAVE: next_rdata = 32'h00000000;
			`FDOD_IDX_DEFAULTS: next_rdata = 32'h00000000;
			`FDOD_IDX_EMCY_ID: begin
				next_rdata = `FDOD_EMCY_BASE | {25'h0000000, i_node_id};
				next_err = i_od_we;
			end
			`FDOD_IDX_HB_CONSUME: next_rdata = heartbeat_consume_timeout;
			`FDOD_IDX_HB_PRODUCE: next_rdata = heartbeat_produce_period;
			`FDOD_IDX_IDENTITY: begin
				next_rdata = IDENTITY_VALUE;
				next_err = i_od_we;
			end
			`FDOD_IDX_RUN_CMD: next_rdata = {16'h0000, run_fault_command_word};
			`FDOD_IDX_SPEED: next_rdata = {16'h0000, speed_reference_word};
			`FDOD_IDX_TORQUE: next_rdata = {16'h0000, torque_reference_word};
			`FDOD_IDX_TORQUE_OFS: next_rdata = {16'h0000, torque_offset_word};
			`FDOD_IDX_IND_READ, `FDOD_IDX_IND_WRITE,
			`FDOD_IDX_IND_READ_RSP, `FDOD_IDX_IND_WRITE_RSP: begin
				if (i_od_subindex == `FDOD_SUB_ENTRIES) begin
					next_rdata = `FDOD_NUM_ENTRIES;
					next_err = i_od_we;
				end else if (i_od_subindex == `FDOD_SUB_DATA) begin
					if (hit(i_od_index, `FDOD_IDX_IND_READ)) begin
						next_rdata = indirect_read_request;
					end else if (hit(i_od_index, `FDOD_IDX_IND_WRITE)) begin
						next_rdata = indirect_write_request;
					end else if (hit(i_od_index, `FDOD_IDX_IND_READ_RSP)) begin
						next_rdata = read_response;
						next_err = i_od_we;
					end else begin
						next_rdata = write_response;
						next_err = i_od_we;
					end
				end else begin
					next_err = 1'b1;
				end
			end
			default: next_err = 1'b1;
		endcase
	end
	// ****************************************************************
	// object access port and settings
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_od_rdata <= 32'h00000000;
			o_od_ack <= 1'b0;
			o_od_err <= 1'b0;
			guard_message_identifier <= `FDOD_DEF_GUARD_ID;
			heartbeat_consume_timeout <= `FDOD_DEF_HB_CONSUME;
			heartbeat_produce_period <= `FDOD_DEF_HB_PRODUCE;
			run_fault_command_word <= 16'h0000;
			speed_reference_word <= 16'h0000;
			torque_reference_word <= 16'h0000;
			torque_offset_word <= 16'h0000;
			indirect_read_request <= 32'h00000000;
			indirect_write_request <= 32'h00000000;
			seq_state <= SQ_LOAD;
			seq_cnt <= `FDOD_SLOT_GUARD;
			seq_rd_valid <= 1'b0;
			seq_rd_slot <= `FDOD_SLOT_GUARD;
			o_busy <= 1'b1;
		end else begin
			o_od_ack <= i_od_req;
			o_od_err <= i_od_req & next_err;
			o_od_rdata <= (i_od_req & ~i_od_we) ? next_rdata : 32'h00000000;
			if (wr & ~next_err) begin
				case (i_od_index)
					`FDOD_IDX_GUARD_ID: guard_message_identifier <= i_od_wdata;
					`FDOD_IDX_HB_CONSUME: heartbeat_consume_timeout <= i_od_wdata;
					`FDOD_IDX_HB_PRODUCE: heartbeat_produce_period <= i_od_wdata;
					`FDOD_IDX_RUN_CMD: run_fault_command_word <= i_od_wdata[15:0];
					`FDOD_IDX_SPEED: speed_reference_word <= i_od_wdata[15:0];
					`FDOD_IDX_TORQUE: torque_reference_word <= i_od_wdata[15:0];
					`FDOD_IDX_TORQUE_OFS: torque_offset_word <= i_od_wdata[15:0];
					`FDOD_IDX_IND_READ: indirect_read_request <= i_od_wdata;
					`FDOD_IDX_IND_WRITE: indirect_write_request <= i_od_wdata;
					`FDOD_IDX_DEFAULTS: begin
						if (i_od_wdata == `FDOD_MAGIC_LOAD) begin
							guard_message_identifier <= `FDOD_DEF_GUARD_ID;
							heartbeat_consume_timeout <= `FDOD_DEF_HB_CONSUME;
							heartbeat_produce_period <= `FDOD_DEF_HB_PRODUCE;
						end
					end
					default: begin
					end
				endcase
			end
			// stored copy is applied one cycle after each slot read
			seq_rd_valid <= (seq_state == SQ_LOAD);
			seq_rd_slot <= seq_cnt;
			if (seq_rd_valid) begin
				case (seq_rd_slot)
					`FDOD_SLOT_GUARD: guard_message_identifier <= nvm_rdata;
					`FDOD_SLOT_CONSUME: heartbeat_consume_timeout <= nvm_rdata;
					`FDOD_SLOT_PRODUCE: heartbeat_produce_period <= nvm_rdata;
					default: begin
					end
				endcase
			end
			case (seq_state)
				SQ_IDLE: begin
					o_busy <= seq_rd_valid;
					seq_cnt <= `FDOD_SLOT_GUARD;
					if (i_node_reset | i_comm_reset) begin
						seq_state <= SQ_LOAD;
						o_busy <= 1'b1;
					end else if (wr & hit(i_od_index, `FDOD_IDX_SAVE) &
							(i_od_wdata == `FDOD_MAGIC_SAVE)) begin
						seq_state <= SQ_SAVE;
						o_busy <= 1'b1;
					end
				end
				SQ_SAVE, SQ_LOAD: begin
					if (seq_cnt == `FDOD_SLOT_PRODUCE) begin
						seq_state <= SQ_IDLE;
					end
					seq_cnt <= seq_cnt + 2'h1;
				end
				default: seq_state <= SQ_IDLE;
			endcase
		end
	end
	// ****************************************************************
	// indirect drive register access
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			acc_state <= ST_IDLE;
			o_drv_req <= 1'b0;
			o_drv_we <= 1'b0;
			o_drv_addr <= 16'h0000;
			o_drv_wdata <= 16'h0000;
			read_response <= 32'h00000000;
			write_response <= 32'h00000000;
		end else begin
			o_drv_req <= 1'b0;
			case (acc_state)
				ST_IDLE: begin
					if (wr & hit(i_od_index, `FDOD_IDX_IND_READ) &
							(i_od_subindex == `FDOD_SUB_DATA) &
							(i_od_wdata[31:16] == 16'h0000)) begin
						o_drv_req <= 1'b1;
						o_drv_we <= 1'b0;
						o_drv_addr <= i_od_wdata[15:0];
						o_drv_wdata <= 16'h0000;
						acc_state <= ST_RD;
					end else if (wr & hit(i_od_index, `FDOD_IDX_IND_WRITE) &
							(i_od_subindex == `FDOD_SUB_DATA)) begin
						o_drv_req <= 1'b1;
						o_drv_we <= 1'b1;
						o_drv_addr <= i_od_wdata[15:0];
						o_drv_wdata <= i_od_wdata[31:16];
						acc_state <= ST_WR;
					end
				end
				ST_RD: begin
					if (i_drv_ack) begin
						read_response <= pack_rsp(o_drv_addr, i_drv_rdata);
						acc_state <= ST_IDLE;
					end
				end
				ST_WR: begin
					if (i_drv_ack) begin
						write_response <= pack_rsp(o_drv_addr, i_drv_rdata);
						acc_state <= ST_IDLE;
					end
				end
				default: acc_state <= ST_IDLE;
			endcase
		end
	end
	// ****************************************************************
	// heartbeat timing
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			ms_cnt <= 16'h0000;
			ms_tick <= 1'b0;
			prod_cnt <= 32'h00000000;
			cons_cnt <= 32'h00000000;
			o_hb_tx <= 1'b0;
			o_hb_timeout <= 1'b0;
		end else begin
			ms_tick <= (ms_cnt == MS_CYCLES - 1);
			ms_cnt <= (ms_cnt == MS_CYCLES - 1) ? 16'h0000 : ms_cnt + 16'h0001;
			o_hb_tx <= 1'b0;
			if (heartbeat_produce_period == 32'h00000000) begin
				prod_cnt <= 32'h00000000;
			end else if (ms_tick) begin
				if (prod_cnt + 32'h00000001 >= heartbeat_produce_period) begin
					prod_cnt <= 32'h00000000;
					o_hb_tx <= 1'b1;
				end else begin
					prod_cnt <= prod_cnt + 32'h00000001;
				end
			end
			if (i_hb_rx) begin
				cons_cnt <= 32'h00000000;
			end else if (ms_tick & ~o_hb_timeout) begin
				cons_cnt <= cons_cnt + 32'h00000001;
			end
			// loss wins over a heartbeat arriving in the same cycle
			if (heartbeat_consume_timeout == 32'h00000000) begin
				o_hb_timeout <= 1'b0;
			end else if (~o_hb_timeout & (cons_cnt >= heartbeat_consume_timeout)) begin
				o_hb_timeout <= 1'b1;
			end else if (i_hb_rx) begin
				o_hb_timeout <= 1'b0;
			end
		end
	end
	// ****************************************************************
	// drive command outputs
	// ****************************************************************
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_run_fwd <= 1'b0;
			o_run_rev <= 1'b0;
			o_multi_input_terminals <= 6'h00;
			o_network_external_fault <= 1'b0;
			o_fault_reset <= 1'b0;
			o_speed_reference <= 16'h0000;
			o_speed_limit <= 16'h0000;
			o_torque_reference <= 16'h0000;
			o_torque_limit <= 16'h0000;
			o_torque_limit_valid <= 1'b0;
			o_torque_offset <= 16'h0000;
		end else begin
			o_run_fwd <= run_fault_command_word[`FDOD_BIT_FWD] &
				(i_run_source_select == `FDOD_RUN_SRC_NET);
			o_run_rev <= run_fault_command_word[`FDOD_BIT_REV] &
				(i_run_source_select == `FDOD_RUN_SRC_NET);
			o_multi_input_terminals <= run_fault_command_word[`FDOD_MFI_HI:`FDOD_MFI_LO];
			o_network_external_fault <= run_fault_command_word[`FDOD_BIT_EXT_FAULT];
			o_fault_reset <= run_fault_command_word[`FDOD_BIT_FAULT_RST];
			o_speed_reference <= (i_control_loop_selector == `FDOD_LOOP_SPEED) ?
				speed_reference_word : 16'h0000;
			o_speed_limit <= (i_control_loop_selector == `FDOD_LOOP_TORQUE) ?
				speed_reference_word : 16'h0000;
			o_torque_reference <= ((i_torque_command_enable == `FDOD_TQ_ENABLE_ON) &
				(i_control_loop_selector == `FDOD_LOOP_TORQUE)) ?
				torque_reference_word : 16'h0000;
			o_torque_limit <= ((i_torque_command_enable == `FDOD_TQ_ENABLE_ON) &
				(i_control_loop_selector == `FDOD_LOOP_SPEED)) ?
				torque_reference_word : 16'h0000;
			o_torque_limit_valid <= (i_torque_command_enable == `FDOD_TQ_ENABLE_ON) &
				(i_control_loop_selector == `FDOD_LOOP_SPEED);
			o_torque_offset <= torque_offset_word;
		end
	end
endmodule

/* File: bench/fdod_drive_model.sv */
`timescale 1ns/1ps
// ****************
// drive register space, answers 1 to 10 cycles after a request
// ****************
module fdod_drive_model #(
	parameter OK_CODE = 16'h0001
) (
	input wire i_clk, // clock
	input wire i_sys_rst, // reset
	input wire i_drv_req, // access pulse
	input wire i_drv_we, // write
	input wire [15:0] i_drv_addr, // register address
	input wire [15:0] i_drv_wdata, // write data
	output reg o_drv_ack, // done pulse
	output reg [15:0] o_drv_rdata // read data or outcome
);
	reg [15:0] mem [0:15];
	reg busy = 1'b0;
	integer i;
	integer left = 0;
	initial begin
		o_drv_ack = 1'b0;
		o_drv_rdata = 16'h0000;
		for (i = 0; i < 16; i = i + 1)
			mem[i] = 16'hC000 + i[15:0];
	end
	always @(posedge i_clk) begin
		o_drv_ack <= 1'b0;
		// between answers the data lines toggle
		o_drv_rdata <= ~o_drv_rdata;
		if (i_sys_rst) begin
			busy <= 1'b0;
		end else if (i_drv_req) begin
			busy <= 1'b1;
			left <= 3 * i_drv_addr[1:0];
		end else if (busy && left > 0) begin
			left <= left - 1;
		end else if (busy) begin
			busy <= 1'b0;
			o_drv_ack <= 1'b1;
			if (i_drv_we) begin
				mem[i_drv_addr[3:0]] <= i_drv_wdata;
				o_drv_rdata <= OK_CODE;
			end else
				o_drv_rdata <= mem[i_drv_addr[3:0]];
		end
	end
endmodule

/* File: bench/fdod_od_chk.sv */
`timescale 1ns/1ps
`include "fdod_map.vh"
module fdod_od_chk (
	input wire i_clk, // clock
	input wire i_sys_rst, // reset
	input wire i_od_req, // access strobe
	input wire i_od_we, // write
	input wire [15:0] i_od_index, // index
	input wire [7:0] i_od_subindex, // subindex
	input wire [31:0] i_od_wdata, // write data
	input wire o_od_ack, // answer
	input wire o_od_err, // refusal
	input wire [7:0] i_run_source_select, // run source
	input wire [7:0] i_control_loop_selector, // loop select
	input wire [7:0] i_torque_command_enable, // torque enable
	input wire o_run_fwd, // forward run
	input wire [15:0] o_speed_limit, // speed limit
	input wire [15:0] o_torque_reference, // torque reference
	input wire o_drv_req, // drive access
	input wire o_drv_we, // drive write
	input wire [15:0] o_drv_addr, // drive address
	input wire i_drv_ack, // drive done
	input wire o_busy // settings busy
);
	reg pend;
	wire rd_req;
	wire [15:0] rd_addr;
	assign rd_addr = i_od_wdata[15:0];
	assign rd_req = i_od_req && i_od_we && i_od_index == `FDOD_IDX_IND_READ
		&& i_od_subindex == `FDOD_SUB_DATA;
	always @(posedge i_clk) begin
		if (i_sys_rst || i_drv_ack)
			pend <= 1'b0;
		else if (o_drv_req)
			pend <= 1'b1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	a_ack_next: assert property (i_od_req |=> o_od_ack) else $error("access not answered");
	a_ack_cause: assert property (o_od_ack |-> $past(i_od_req)) else $error("stray answer");
	a_err_ack: assert property (o_od_err |-> o_od_ack) else $error("refusal without answer");
	a_run_gate: assert property (o_run_fwd |-> $past(i_run_source_select) == 8'h03)
		else $error("run without network run source");
	a_tq_gate: assert property (o_torque_reference != 16'h0 |->
		$past(i_torque_command_enable) == 8'h01 && $past(i_control_loop_selector) == 8'h01)
		else $error("torque reference while not allowed");
	a_spd_limit: assert property (o_speed_limit != 16'h0 |->
		$past(i_control_loop_selector) == 8'h01) else $error("speed limit in speed control");
	a_rd_ignore: assert property (rd_req && i_od_wdata[31:16] != 16'h0 |=> !o_drv_req)
		else $error("bad read request launched");
	a_rd_launch: assert property (rd_req && i_od_wdata[31:16] == 16'h0 && !pend &&
		!o_drv_req |=> o_drv_req && !o_drv_we && o_drv_addr == $past(rd_addr))
		else $error("read request not launched");
	a_busy_rst: assert property ($fell(i_sys_rst) |-> o_busy)
		else $error("no settings load after reset");
	c_err: cover property (o_od_err);
	c_drv_wr: cover property (o_drv_req && o_drv_we);
	c_load: cover property ($fell(o_busy));
endmodule
bind fdod_object_dictionary fdod_od_chk i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_od_req(i_od_req), .i_od_we(i_od_we), .i_od_index(i_od_index),
	.i_od_subindex(i_od_subindex), .i_od_wdata(i_od_wdata), .o_od_ack(o_od_ack),
	.o_od_err(o_od_err), .i_run_source_select(i_run_source_select),
	.i_control_loop_selector(i_control_loop_selector), .o_run_fwd(o_run_fwd),
	.i_torque_command_enable(i_torque_command_enable), .o_speed_limit(o_speed_limit),
	.o_torque_reference(o_torque_reference), .o_drv_req(o_drv_req), .o_drv_we(o_drv_we),
	.o_drv_addr(o_drv_addr), .i_drv_ack(i_drv_ack), .o_busy(o_busy));

/* File: bench/fdod_object_dictionary_tb.sv */
`timescale 1ns/1ps
`include "fdod_map.vh"
module fdod_object_dictionary_tb;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_od_req = 1'b0, i_od_we = 1'b0;
	logic i_node_reset = 1'b0, i_comm_reset = 1'b0, i_hb_rx = 1'b0, i_drv_ack;
	logic [15:0] i_od_index = 16'h0000, i_drv_rdata, v, s, t, q;
	logic [7:0] i_od_subindex = 8'h00, i_run_source_select = 8'h00;
	logic [7:0] i_control_loop_selector = 8'h00, i_torque_command_enable = 8'h00;
	logic [31:0] i_od_wdata = 32'h00000000, o_od_rdata;
	logic [6:0] i_node_id = 7'h15;
	logic o_od_ack, o_od_err, o_hb_tx, o_hb_timeout, o_run_fwd, o_run_rev, o_busy;
	logic o_network_external_fault, o_fault_reset, o_torque_limit_valid, o_drv_req, o_drv_we;
	logic [5:0] o_multi_input_terminals;
	logic [15:0] o_speed_reference, o_speed_limit, o_torque_reference, o_torque_limit;
	logic [15:0] o_torque_offset, o_drv_addr, o_drv_wdata;
	logic [32:0] expq[$];
	logic [32:0] e;
	integer fail_count = 0, cmp_count = 0, seed, k, n;
	localparam logic [32:0] ERR = 33'h100000000, OK0 = 33'h0;
	always #10 i_clk = ~i_clk;
	fdod_object_dictionary #(.MS_CYCLES(10)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_od_req(i_od_req), .i_od_we(i_od_we), .i_od_index(i_od_index),
		.i_od_subindex(i_od_subindex), .i_od_wdata(i_od_wdata), .o_od_rdata(o_od_rdata),
		.o_od_ack(o_od_ack), .o_od_err(o_od_err), .i_node_reset(i_node_reset),
		.i_comm_reset(i_comm_reset), .i_node_id(i_node_id), .i_hb_rx(i_hb_rx),
		.o_hb_tx(o_hb_tx), .o_hb_timeout(o_hb_timeout), .o_run_fwd(o_run_fwd),
		.i_run_source_select(i_run_source_select), .o_run_rev(o_run_rev),
		.i_control_loop_selector(i_control_loop_selector), .o_busy(o_busy),
		.i_torque_command_enable(i_torque_command_enable), .o_fault_reset(o_fault_reset),
		.o_multi_input_terminals(o_multi_input_terminals), .o_speed_limit(o_speed_limit),
		.o_network_external_fault(o_network_external_fault), .o_drv_req(o_drv_req),
		.o_speed_reference(o_speed_reference), .o_torque_reference(o_torque_reference),
		.o_torque_limit(o_torque_limit), .o_torque_limit_valid(o_torque_limit_valid),
		.o_torque_offset(o_torque_offset), .o_drv_we(o_drv_we), .o_drv_addr(o_drv_addr),
		.o_drv_wdata(o_drv_wdata), .i_drv_ack(i_drv_ack), .i_drv_rdata(i_drv_rdata));
	fdod_drive_model i_drive (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_drv_req(o_drv_req),
		.i_drv_we(o_drv_we), .i_drv_addr(o_drv_addr), .i_drv_wdata(o_drv_wdata),
		.o_drv_ack(i_drv_ack), .o_drv_rdata(i_drv_rdata));
	task step(input integer c);
		repeat (c) @(posedge i_clk);
		#1;
	endtask
	task check(input logic [32:0] seen, input logic [32:0] want);
		cmp_count = cmp_count + 1;
		if (seen !== want) begin
			fail_count = fail_count + 1;
			$display("unexpected at %0t: seen %0h wanted %0h", $time, seen, want);
		end
	endtask
	task od(input logic we, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic [32:0] want);
		{i_od_req, i_od_we, i_od_index, i_od_subindex, i_od_wdata} = {1'b1, we, idx, sub, wd};
		expq.push_back(want);
		step(1);
		i_od_req = 1'b0;
		step(1);
	endtask
	task idle;
		step(2);
		for (n = 0; n < 50 && o_busy !== 1'b0; n = n + 1) step(1);
		check(33'(n < 50), 33'h1);
	endtask
	task rx;
		i_hb_rx = 1'b1;
		step(1);
		i_hb_rx = 1'b0;
	endtask
	task count(input integer c);
		n = 0;
		repeat (c) begin
			n = n + (o_hb_tx === 1'b1);
			step(1);
		end
	endtask
	task ind(input logic [15:0] ri, input logic [31:0] wd, input logic [15:0] rsp,
		input logic [32:0] want);
		od(1'b1, ri, 8'h01, wd, OK0);
		step(15);
		od(1'b0, rsp, 8'h01, 32'h0, want);
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(negedge i_clk) begin
		if (o_od_ack === 1'b1) begin
			e = (expq.size() == 0) ? 33'h1FFFFFFFF : expq.pop_front();
			check({o_od_err, o_od_rdata}, e);
		end
	end
	initial begin
		repeat (5000) @(posedge i_clk);
		fail_count = fail_count + 1;
		close_out;
	end
	initial begin
		seed = 32'hD1AF;
		step(12);
		i_sys_rst = 1'b0;
		idle;
		od(1'b0, 16'h3000, 8'h01, 32'h0, ERR);
		od(1'b1, `FDOD_IDX_EMCY_ID, 8'h01, 32'h1, ERR);
		od(1'b1, `FDOD_IDX_IDENTITY, 8'h01, 32'h1, ERR);
		od(1'b1, `FDOD_IDX_IND_WRITE_RSP, 8'h01, 32'h1, ERR);
		od(1'b0, `FDOD_IDX_EMCY_ID, 8'h01, 32'h0, 33'h95);
		od(1'b1, `FDOD_IDX_GUARD_ID, 8'h01, 32'h123, OK0);
		od(1'b1, `FDOD_IDX_SAVE, 8'h01, `FDOD_MAGIC_SAVE, OK0);
		idle;
		od(1'b1, `FDOD_IDX_GUARD_ID, 8'h01, 32'h456, OK0);
		od(1'b1, `FDOD_IDX_SAVE, 8'h01, 32'h65766174, OK0);
		idle;
		od(1'b0, `FDOD_IDX_GUARD_ID, 8'h01, 32'h0, 33'h456);
		i_node_reset = 1'b1;
		step(1);
		i_node_reset = 1'b0;
		idle;
		od(1'b0, `FDOD_IDX_GUARD_ID, 8'h01, 32'h0, 33'h123);
		od(1'b1, `FDOD_IDX_DEFAULTS, 8'h01, 32'h64616F6D, OK0);
		od(1'b0, `FDOD_IDX_GUARD_ID, 8'h01, 32'h0, 33'h123);
		od(1'b1, `FDOD_IDX_DEFAULTS, 8'h01, `FDOD_MAGIC_LOAD, OK0);
		step(2);
		od(1'b0, `FDOD_IDX_GUARD_ID, 8'h01, 32'h0, 33'(`FDOD_DEF_GUARD_ID));
		i_comm_reset = 1'b1;
		step(1);
		i_comm_reset = 1'b0;
		idle;
		od(1'b0, `FDOD_IDX_GUARD_ID, 8'h01, 32'h0, 33'h123);
		od(1'b1, `FDOD_IDX_HB_PRODUCE, 8'h01, 32'h3, OK0);
		step(40);
		count(300);
		check(33'(n), 33'd10);
		od(1'b1, `FDOD_IDX_HB_PRODUCE, 8'h01, 32'h0, OK0);
		step(5);
		count(300);
		check(33'(n), 33'd0);
		od(1'b1, `FDOD_IDX_HB_CONSUME, 8'h01, 32'h4, OK0);
		repeat (6) begin
			rx;
			step(20);
		end
		check(33'(o_hb_timeout), 33'h0);
		step(50);
		check(33'(o_hb_timeout), 33'h1);
		rx;
		step(1);
		check(33'(o_hb_timeout), 33'h0);
		step(50);
		od(1'b1, `FDOD_IDX_HB_CONSUME, 8'h01, 32'h0, OK0);
		step(60);
		check(33'(o_hb_timeout), 33'h0);
		for (k = 0; k < 6; k = k + 1) begin
			v = 16'($random(seed));
			i_run_source_select = k[0] ? 8'h03 : 8'h02;
			od(1'b1, `FDOD_IDX_RUN_CMD, 8'h00, {16'h0, v}, OK0);
			step(2);
			check(33'({o_run_fwd, o_run_rev}), 33'(k[0] ? {v[0], v[1]} : 2'b00));
			check(33'(o_multi_input_terminals), 33'(v[7:2]));
			check(33'({o_network_external_fault, o_fault_reset}), 33'({v[8], v[9]}));
		end
		for (k = 0; k < 4; k = k + 1) begin
			{s, t, q} = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
			{i_control_loop_selector, i_torque_command_enable} = {7'h0, k[0], 7'h0, k[1]};
			od(1'b1, `FDOD_IDX_SPEED, 8'h00, {16'h0, s}, OK0);
			od(1'b1, `FDOD_IDX_TORQUE, 8'h00, {16'h0, t}, OK0);
			od(1'b1, `FDOD_IDX_TORQUE_OFS, 8'h00, {16'h0, q}, OK0);
			step(2);
			check(33'({o_speed_reference, o_speed_limit}), k[0] ? 33'(s) : 33'({s, 16'h0}));
			check(33'({o_torque_reference, o_torque_limit, o_torque_limit_valid}), !k[1] ? 33'h0 :
				k[0] ? 33'({t, 17'h0}) : 33'({t, 1'b1}));
			check(33'(o_torque_offset), 33'(q));
		end
		od(1'b0, `FDOD_IDX_IND_READ, 8'h00, 32'h0, 33'h1);
		ind(`FDOD_IDX_IND_READ, 32'h6, `FDOD_IDX_IND_READ_RSP, 33'hC0060006);
		ind(`FDOD_IDX_IND_WRITE, 32'hBEEF0006, `FDOD_IDX_IND_WRITE_RSP, 33'h10006);
		ind(`FDOD_IDX_IND_READ, 32'h6, `FDOD_IDX_IND_READ_RSP, 33'hBEEF0006);
		ind(`FDOD_IDX_IND_READ, 32'h10003, `FDOD_IDX_IND_READ_RSP, 33'hBEEF0006);
		ind(`FDOD_IDX_IND_READ, 32'hB, `FDOD_IDX_IND_READ_RSP, 33'hC00B000B);
		ind(`FDOD_IDX_IND_READ, 32'h4, `FDOD_IDX_IND_READ_RSP, 33'hC0040004);
		step(5);
		check(33'(expq.size()), 33'h0);
		close_out;
	end
endmodule
